// ---- design/vqw_consts.svh ----
// Named offsets, field positions, reset values and codes of the walker.
// Assumes inclusion by bare name from the walker module and the bench top.
`ifndef VQW_CONSTS_SVH
`define VQW_CONSTS_SVH
`define VQW_OFS_CTRL     12'h000
`define VQW_OFS_QLOG     12'h004
`define VQW_OFS_DESC     12'h008
`define VQW_OFS_AVAIL    12'h00C
`define VQW_OFS_USED     12'h010
`define VQW_OFS_STAT     12'h014
`define VQW_OFS_IDX      12'h018
`define VQW_CTRL_EN      0
`define VQW_CTRL_EVT     1
`define VQW_RST_WORD     32'h0000_0000
`define VQW_RST_QLOG     4'h0
`define VQW_F_NEXT       0
`define VQW_F_WRITE      1
`define VQW_F_IND        2
`define VQW_RING_HDR     32'h0000_0004
`define VQW_LEN_OFS      32'h0000_0004
`define VQW_BE_HI        4'hC
`define VQW_BE_ALL       4'hF
`define VQW_LAST_BEAT    2'h3
`define VQW_ERR_NONE     3'h0
`define VQW_ERR_LONG     3'h1
`define VQW_ERR_NEST     3'h2
`define VQW_ERR_INDNEXT  3'h3
`define VQW_ERR_RANGE    3'h4
`endif

// ---- design/vqw_pkg.sv ----
// Types shared by the descriptor walker and its surroundings.
// Assumes the constants header is on the include path.
`default_nettype none
package vqw_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_AIDX, S_HEAD, S_DESC, S_EMIT, S_WAIT,
    S_WID, S_WLEN, S_WUIDX, S_EVT, S_HALT
  } vqw_state_e;

  // One buffer of a walked chain, handed to the user side.
  typedef struct packed {
    logic [63:0] addr;
    logic [31:0] len;
    logic        write;
    logic        last;
    logic [15:0] head;
  } vqw_elem_s;

  // One word access to guest memory.
  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } vqw_memreq_s;
endpackage
`default_nettype wire

// ---- design/vqw_walker.sv ----
// Split virtqueue descriptor walker with an APB register slave.
// Assumes a word memory port that answers with mem_ack_in on core_clk_in.
// Rules of the document for this block and its driver
// RULE1 - Any split of a message across descriptors is accepted.
// RULE2 - Driver puts writable descriptors after readable ones.
// RULE3 - Descriptor is 16 bytes: address, length, flags, next.
// RULE4 - Flag 1 continues, 2 marks writable, 4 marks indirect table.
// RULE5 - Continuation flag fetches the next index; clear flag ends chain.
// RULE6 - Table has queue-size entries, which bounds chain length.
// RULE7 - Never write readable buffers; do not read writable ones.
// RULE8 - Driver keeps chain total below four gigabytes, so no loops.
// RULE9 - Indirect table holds length/16 entries, walked from entry zero.
// RULE10 - Driver uses indirect only when negotiated and never nested.
// RULE11 - Driver builds no chain longer than the queue size.
// RULE12 - Driver never sets indirect and continuation together.
// RULE13 - Writable flag on an indirect pointer is ignored.
// RULE14 - Linked descriptors may end in one indirect descriptor.
// RULE15 - Available ring is flags, index, heads, used_event; read only.
// RULE16 - Available index is free-running from zero, taken modulo size.
// RULE17 - Without event index, interrupt when available flags are zero.
// RULE18 - With event index, interrupt when used index equals used_event.
// RULE19 - Event index compare wraps at sixteen bits.
// RULE20 - Driver writes flags zero or one, zero with event index.
// RULE21 - Driver tolerates spurious interrupts.
// RULE22 - Used entry is a 32-bit head index then 32-bit written count.
// RULE23 - Queue size is a power of two up to 32768; index is masked.
// RULE24 - Reset clears both indices and drops any partial chain.
// RULE25 - Overlong, nested or indirect-plus-next chains halt with error.
`timescale 1ns/1ps
`default_nettype none
`include "vqw_consts.svh"
module vqw_walker
  import vqw_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             mem_req_out,
  output vqw_memreq_s      mem_cmd_out,
  input  wire logic [31:0] mem_rdata_in,
  input  wire logic        mem_ack_in,
  output logic             elem_valid_out,
  output vqw_elem_s        elem_out,
  input  wire logic        elem_ready_in,
  input  wire logic        done_in,
  input  wire logic [31:0] done_len_in,
  output logic             irq_out,
  output logic             err_out
);
  logic              en_q, en_d, evt_q, evt_d;
  logic [3:0]        qlog_q, qlog_d;
  logic [31:0]       dbase_q, dbase_d, abase_q, abase_d, ubase_q, ubase_d;
  logic [31:0]       prdata_q, prdata_d;
  logic              apb_acc, apb_hit, err_clr;
  vqw_state_e        st_q, st_d;
  logic [1:0]        beat_q, beat_d;
  logic [27:0]       cnt_q, cnt_d, ient_q, ient_d, lim;
  logic              ind_q, ind_d, irq_q, irq_d, err_q, err_d;
  logic [31:0]       ibase_q, ibase_d, dlen_q, dlen_d;
  logic [31:0]       w0_q, w0_d, w1_q, w1_d, w2_q, w2_d;
  logic [15:0]       cur_q, cur_d, head_q, head_d;
  logic [15:0]       lavail_q, lavail_d, uidx_q, uidx_d;
  logic [2:0]        ecode_q, ecode_d;
  vqw_elem_s         elem_q, elem_d;
  logic [16:0]       qsize;
  logic [15:0]       qmask, hsel, esel, dflags, dnext;
  logic [31:0]       hd_addr, ev_addr, tbase;

  // Queue size is a power of two; ring slots come from masking the index.
  assign qsize   = 17'(17'h1 << qlog_q); // see RULE23
  assign qmask   = 16'(qsize - 17'h1);
  assign hd_addr = abase_q + `VQW_RING_HDR + {15'h0, lavail_q & qmask, 1'b0};
  assign ev_addr = abase_q + `VQW_RING_HDR + {14'h0, qsize, 1'b0};
  assign hsel    = hd_addr[1] ? mem_rdata_in[31:16] : mem_rdata_in[15:0];
  assign esel    = ev_addr[1] ? mem_rdata_in[31:16] : mem_rdata_in[15:0];
  assign dflags  = mem_rdata_in[15:0];
  assign dnext   = mem_rdata_in[31:16];
  assign tbase   = ind_q ? ibase_q : dbase_q;
  assign lim     = ind_q ? ient_q : {11'h0, qsize};

  // APB decode: zero-wait access phase, read data latched in setup.
  assign apb_acc     = psel_in & penable_in;
  assign pready_out  = apb_acc;
  assign pslverr_out = apb_acc & ~apb_hit;
  assign prdata_out  = prdata_q;
  assign err_clr     = apb_acc & pwrite_in & (paddr_in == `VQW_OFS_STAT)
                       & pwdata_in[0];

  // Register file next values and read multiplexer.
  always_comb begin
    en_d     = en_q;
    evt_d    = evt_q;
    qlog_d   = qlog_q;
    dbase_d  = dbase_q;
    abase_d  = abase_q;
    ubase_d  = ubase_q;
    prdata_d = `VQW_RST_WORD;
    apb_hit  = 1'b1;
    unique case (paddr_in)
      `VQW_OFS_CTRL:  prdata_d = {30'h0, evt_q, en_q};
      `VQW_OFS_QLOG:  prdata_d = {28'h0, qlog_q};
      `VQW_OFS_DESC:  prdata_d = dbase_q;
      `VQW_OFS_AVAIL: prdata_d = abase_q;
      `VQW_OFS_USED:  prdata_d = ubase_q;
      `VQW_OFS_STAT:  prdata_d = {27'h0, ecode_q, st_q != S_IDLE, err_q};
      `VQW_OFS_IDX:   prdata_d = {uidx_q, lavail_q};
      default: apb_hit = 1'b0;
    endcase
    if (!(psel_in & ~penable_in)) prdata_d = prdata_q;
    if (apb_acc & pwrite_in) begin
      unique case (paddr_in)
        `VQW_OFS_CTRL: begin
          en_d  = pwdata_in[`VQW_CTRL_EN];
          evt_d = pwdata_in[`VQW_CTRL_EVT];
        end
        `VQW_OFS_QLOG:  qlog_d = pwdata_in[3:0];
        `VQW_OFS_DESC:  dbase_d = pwdata_in;
        `VQW_OFS_AVAIL: abase_d = pwdata_in;
        `VQW_OFS_USED:  ubase_d = pwdata_in;
        default: ;
      endcase
    end
  end

  // Register file flip-flops.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      en_q     <= 1'b0;
      evt_q    <= 1'b0;
      qlog_q   <= `VQW_RST_QLOG;
      dbase_q  <= `VQW_RST_WORD;
      abase_q  <= `VQW_RST_WORD;
      ubase_q  <= `VQW_RST_WORD;
      prdata_q <= `VQW_RST_WORD;
    end else begin
      en_q     <= en_d;
      evt_q    <= evt_d;
      qlog_q   <= qlog_d;
      dbase_q  <= dbase_d;
      abase_q  <= abase_d;
      ubase_q  <= ubase_d;
      prdata_q <= prdata_d;
    end
  end

  // Memory command for the current state; only ring words are written.
  always_comb begin
    mem_req_out       = 1'b1;
    mem_cmd_out       = '0;
    mem_cmd_out.be    = `VQW_BE_ALL;
    unique case (st_q)
      S_AIDX: mem_cmd_out.addr = abase_q; // see RULE15
      S_HEAD: mem_cmd_out.addr = {hd_addr[31:2], 2'b00};
      S_DESC: mem_cmd_out.addr = tbase + {12'h0, cur_q, 4'h0}
                                 + {28'h0, beat_q, 2'b00}; // see RULE3
      S_WID: begin
        mem_cmd_out.we    = 1'b1; // see RULE7
        mem_cmd_out.addr  = ubase_q + `VQW_RING_HDR
                            + {13'h0, uidx_q & qmask, 3'h0};
        mem_cmd_out.wdata = {16'h0, head_q}; // see RULE22
      end
      S_WLEN: begin
        mem_cmd_out.we    = 1'b1;
        mem_cmd_out.addr  = ubase_q + `VQW_RING_HDR + `VQW_LEN_OFS
                            + {13'h0, uidx_q & qmask, 3'h0};
        mem_cmd_out.wdata = dlen_q;
      end
      S_WUIDX: begin
        mem_cmd_out.we    = 1'b1;
        mem_cmd_out.addr  = ubase_q;
        mem_cmd_out.be    = `VQW_BE_HI;
        mem_cmd_out.wdata = {16'(uidx_q + 16'h1), 16'h0};
      end
      S_EVT: mem_cmd_out.addr = evt_q ? {ev_addr[31:2], 2'b00} : abase_q;
      default: mem_req_out = 1'b0;
    endcase
  end

  assign elem_valid_out = (st_q == S_EMIT);
  assign elem_out       = elem_q;
  assign irq_out        = irq_q;
  assign err_out        = err_q;

  // Walker next state: fetch heads, walk chains, post used entries.
  always_comb begin
    st_d = st_q;  beat_d = beat_q;  cnt_d = cnt_q;  ind_d = ind_q;
    ient_d = ient_q;  ibase_d = ibase_q;  dlen_d = dlen_q;
    w0_d = w0_q;  w1_d = w1_q;  w2_d = w2_q;  cur_d = cur_q;
    head_d = head_q;  lavail_d = lavail_q;  uidx_d = uidx_q;
    ecode_d = ecode_q;  elem_d = elem_q;  irq_d = 1'b0;  err_d = err_q;
    if (err_clr) begin
      err_d   = 1'b0;
      ecode_d = `VQW_ERR_NONE;
    end
    unique case (st_q)
      S_IDLE: if (en_q && !err_q) st_d = S_AIDX;
      S_AIDX: if (mem_ack_in) begin // see RULE16
        // Slots below the driver's index are ready to consume.
        st_d = (mem_rdata_in[31:16] != lavail_q) ? S_HEAD : S_IDLE;
      end
      S_HEAD: if (mem_ack_in) begin
        head_d = hsel;
        cur_d  = hsel;
        ind_d  = 1'b0;
        cnt_d  = 28'h1;
        beat_d = 2'h0;
        st_d   = S_DESC;
        if ({1'b0, hsel} >= qsize) begin
          st_d = S_HALT;
          err_d = 1'b1;
          ecode_d = `VQW_ERR_RANGE;
        end
      end
      S_DESC: if (mem_ack_in) begin
        beat_d = 2'(beat_q + 2'h1);
        unique case (beat_q)
          2'h0: w0_d = mem_rdata_in;
          2'h1: w1_d = mem_rdata_in;
          2'h2: w2_d = mem_rdata_in;
          default: ;
        endcase
        if (beat_q == `VQW_LAST_BEAT) begin // Beat count wraps to zero.
          if (dflags[`VQW_F_IND]) begin
            // Direction of the pointer itself is ignored.
            st_d = S_HALT; // see RULE13, RULE25
            err_d = 1'b1;
            if (ind_q) ecode_d = `VQW_ERR_NEST;
            else if (dflags[`VQW_F_NEXT]) ecode_d = `VQW_ERR_INDNEXT;
            else if (w2_q[31:4] == 28'h0) ecode_d = `VQW_ERR_RANGE;
            else begin
              st_d    = S_DESC; // see RULE9, RULE14
              err_d   = err_q & ~err_clr;
              ind_d   = 1'b1;
              ibase_d = w0_q;
              ient_d  = w2_q[31:4];
              cur_d   = 16'h0;
              cnt_d   = 28'h1;
            end
          end else begin
            elem_d = '{addr: {w1_q, w0_q}, len: w2_q,
                       write: dflags[`VQW_F_WRITE], // see RULE4
                       last: ~dflags[`VQW_F_NEXT], head: head_q};
            cur_d = dnext; // see RULE5
            st_d  = S_EMIT;
          end
        end
      end
      S_EMIT: if (elem_ready_in) begin
        if (elem_q.last) st_d = S_WAIT;
        else if (cnt_q >= lim) begin
          st_d = S_HALT; // see RULE6, RULE25
          err_d = 1'b1;
          ecode_d = `VQW_ERR_LONG;
        end else if ({12'h0, cur_q} >= lim) begin
          st_d = S_HALT;
          err_d = 1'b1;
          ecode_d = `VQW_ERR_RANGE;
        end else begin
          cnt_d = 28'(cnt_q + 28'h1); // see RULE1
          st_d  = S_DESC;
        end
      end
      S_WAIT: if (done_in) begin
        dlen_d = done_len_in;
        st_d   = S_WID;
      end
      S_WID:   if (mem_ack_in) st_d = S_WLEN;
      S_WLEN:  if (mem_ack_in) st_d = S_WUIDX;
      S_WUIDX: if (mem_ack_in) st_d = S_EVT;
      S_EVT: if (mem_ack_in) begin
        // Interrupt decision follows the negotiated suppression scheme.
        irq_d = evt_q ? (esel == uidx_q) // see RULE18, RULE19
                      : (mem_rdata_in[15:0] == 16'h0); // see RULE17
        uidx_d   = 16'(uidx_q + 16'h1);
        lavail_d = 16'(lavail_q + 16'h1);
        st_d     = S_IDLE;
      end
      S_HALT: if (!err_q) st_d = S_IDLE;
    endcase
  end

  // Walker flip-flops; reset drops any partly walked chain.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= S_IDLE;  beat_q <= 2'h0;  cnt_q <= 28'h0;  ind_q <= 1'b0;
      ient_q <= 28'h0;  ibase_q <= `VQW_RST_WORD;  dlen_q <= `VQW_RST_WORD;
      w0_q <= `VQW_RST_WORD;  w1_q <= `VQW_RST_WORD;  w2_q <= `VQW_RST_WORD;
      cur_q <= 16'h0;  head_q <= 16'h0;  elem_q <= '0;
      lavail_q <= 16'h0;  uidx_q <= 16'h0; // see RULE24
      ecode_q <= `VQW_ERR_NONE;  irq_q <= 1'b0;  err_q <= 1'b0;
    end else begin
      st_q <= st_d;  beat_q <= beat_d;  cnt_q <= cnt_d;  ind_q <= ind_d;
      ient_q <= ient_d;  ibase_q <= ibase_d;  dlen_q <= dlen_d;
      w0_q <= w0_d;  w1_q <= w1_d;  w2_q <= w2_d;
      cur_q <= cur_d;  head_q <= head_d;  elem_q <= elem_d;
      lavail_q <= lavail_d;  uidx_q <= uidx_d;
      ecode_q <= ecode_d;  irq_q <= irq_d;  err_q <= err_d;
    end
  end

  a_write_only_ring: assert property (@(posedge core_clk_in) // see RULE7
    disable iff (!nrst_in) mem_req_out && mem_cmd_out.we |->
    st_q inside {S_WID, S_WLEN, S_WUIDX}) else $error("buffer write");
  a_used_idx_lanes: assert property (@(posedge core_clk_in) // see RULE22
    disable iff (!nrst_in) st_q == S_WUIDX |-> mem_cmd_out.be == `VQW_BE_HI
    && mem_cmd_out.wdata[31:16] == 16'(uidx_q + 16'h1))
    else $error("used index write wrong");
  a_ind_enter: assert property (@(posedge core_clk_in) // see RULE9
    disable iff (!nrst_in) st_q == S_DESC && mem_ack_in && beat_q == 2'h3
    && dflags[2] && !ind_q && !dflags[0] && w2_q[31:4] != 28'h0 |=>
    st_q == S_DESC && ind_q && cur_q == 16'h0 && ient_q == $past(w2_q[31:4]))
    else $error("indirect table not entered");
  a_nest_halts: assert property (@(posedge core_clk_in) // see RULE25
    disable iff (!nrst_in) st_q == S_DESC && mem_ack_in && beat_q == 2'h3
    && dflags[2] && ind_q |=> err_q && ecode_q == 3'h2 && st_q == S_HALT)
    else $error("nested table not flagged");
  a_irq_flags: assert property (@(posedge core_clk_in) // see RULE17
    disable iff (!nrst_in) st_q == S_EVT && mem_ack_in && !evt_q |=>
    irq_out == ($past(mem_rdata_in[15:0]) == 16'h0))
    else $error("flags interrupt wrong");
  a_irq_event: assert property (@(posedge core_clk_in) // see RULE18
    disable iff (!nrst_in) irq_out |-> $past(st_q) == S_EVT &&
    (!evt_q || $past(esel) == 16'(uidx_q - 16'h1)))
    else $error("event interrupt wrong");
  a_used_step: assert property (@(posedge core_clk_in) // see RULE19
    disable iff (!nrst_in) uidx_q != $past(uidx_q) |->
    uidx_q == 16'($past(uidx_q) + 16'h1) && lavail_q != $past(lavail_q))
    else $error("used index step wrong");
  a_elem_hold: assert property (@(posedge core_clk_in) // see RULE5
    disable iff (!nrst_in) elem_valid_out && !elem_ready_in |=>
    elem_valid_out && $stable(elem_out)) else $error("element dropped");
  a_chain_bound: assert property (@(posedge core_clk_in) // see RULE6
    disable iff (!nrst_in) st_q == S_DESC && !ind_q |->
    cnt_q <= {11'h0, qsize}) else $error("chain exceeds queue size");
endmodule
`default_nettype wire

// ---- tb/vqw_mem.sv ----
// Guest memory model on the walker's word port: tables and rings.
// Assumes one command held until acknowledged, on the walker's clock.
`timescale 1ns/1ps
`default_nettype none
module vqw_mem
  import vqw_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        req_in,
  input  wire vqw_memreq_s cmd_in,
  input  wire logic        slow_in,
  output logic      [31:0] rdata_out,
  output logic             ack_out
);
  logic [31:0] mem [0:1023];
  logic [1:0]  wait_q;
  int          bad_writes = 0;

  // Answers at once or after two idle cycles; read data then turns to
  // its inverse so that a stale word never passes for a fresh one.
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_out   <= 1'b0;
      wait_q    <= 2'h0;
      rdata_out <= 32'h0000_0000;
    end else if (ack_out) begin
      ack_out   <= 1'b0;
      rdata_out <= ~rdata_out;
      wait_q    <= slow_in ? 2'h2 : 2'h0;
      if (cmd_in.we) begin
        // Only the used ring area may ever be written
        if (cmd_in.addr[11:9] != 3'h3) bad_writes <= bad_writes + 1;
        for (int b = 0; b < 4; b++) begin
          if (cmd_in.be[b])
            mem[cmd_in.addr[11:2]][8*b+:8] <= cmd_in.wdata[8*b+:8];
        end
      end
    end else if (req_in && wait_q == 2'h0) begin
      ack_out   <= 1'b1;
      rdata_out <= mem[cmd_in.addr[11:2]];
    end else if (req_in) begin
      wait_q <= wait_q - 2'h1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/vqw_walker_tb_top.sv ----
// Self-checking bench: registers over APB, chains in a memory model,
// element and completion handshakes, interrupt decisions and errors.
// Assumes the walker package and constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "vqw_consts.svh"
module vqw_walker_tb_top
  import vqw_pkg::*;
;
  logic        clk, nrst, psel, pen, pwr, prdy, perr, er, mreq, mack;
  logic        slow, ev, erdy, done, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mrd, dlen, rd, seed;
  logic [15:0] aidx, uidx, h, fl, ue;
  logic [63:0] e_addr [0:3];
  logic [31:0] e_len [0:3];
  logic        e_wr [0:3];
  vqw_memreq_s mcmd;
  vqw_elem_s   elem;
  int          num_errors, checks, n, nw, w;
  int          irqs = 0;

  vqw_walker vqw_walker_inst (.core_clk_in(clk), .nrst_in(nrst),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(prdy),
    .pslverr_out(perr), .mem_req_out(mreq), .mem_cmd_out(mcmd),
    .mem_rdata_in(mrd), .mem_ack_in(mack), .elem_valid_out(ev),
    .elem_out(elem), .elem_ready_in(erdy), .done_in(done),
    .done_len_in(dlen), .irq_out(irq), .err_out(err));
  vqw_mem vqw_mem_inst (.core_clk_in(clk), .nrst_in(nrst), .req_in(mreq),
    .cmd_in(mcmd), .slow_in(slow), .rdata_out(mrd), .ack_out(mack));

  // Clock of 50 ns and a count of interrupt pulses, checked exactly after each chain.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (irq === 1'b1) irqs <= irqs + 1;

  // Random source, comparison, verdict and the APB master.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (prdy !== 1'b1 && k < 50);
    if (prdy !== 1'b1) num_errors++;
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // Driver side: descriptors, ring slots and the interrupt expectation.
  task automatic put_h(input int a, input logic hi, input logic [15:0] v);
    if (hi) vqw_mem_inst.mem[a][31:16] = v;
    else vqw_mem_inst.mem[a][15:0] = v;
  endtask
  task automatic desc(input int a, input logic [63:0] ad,
                      input logic [31:0] l, input logic [15:0] f,
                      input logic [15:0] nx);
    vqw_mem_inst.mem[a] = ad[31:0];
    vqw_mem_inst.mem[a+1] = ad[63:32];
    vqw_mem_inst.mem[a+2] = l;
    vqw_mem_inst.mem[a+3] = {nx, f};
  endtask
  task automatic publish(input logic [15:0] hd, input logic [15:0] f,
                         input logic [15:0] u);
    put_h(32'h101 + aidx[1], aidx[0], hd);
    put_h(32'h103, 1'b0, u);
    aidx++;
    vqw_mem_inst.mem[32'h100] = {aidx, f};
  endtask
  function automatic logic want(logic evt, logic [15:0] f, logic [15:0] u);
    return evt ? u === uidx : f[0] === 1'b0;
  endfunction

  // Waits for a halt, checks its code, then disables and clears it.
  task automatic halt_code(input logic [2:0] c);
    int t;
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (err !== 1'b1 && t < 3000);
    check(err, 1'b1);
    apb(1'b0, `VQW_OFS_STAT, 32'h0);
    check({rd[4:2], rd[0]}, {c, 1'b1});
    apb(1'b1, `VQW_OFS_CTRL, 32'h0);
    apb(1'b1, `VQW_OFS_STAT, 32'h0000_0001);
    apb(1'b0, `VQW_OFS_STAT, 32'h0);
    check({err, rd[0]}, 2'b00);
  endtask

  // Takes a chain's elements, completes it and checks the used ring.
  task automatic run(input logic [15:0] hd, input int cnt, input logic ei);
    int k, i0, s;
    logic [31:0] dl;
    logic [63:0] x;
    i0 = irqs;
    dl = xs() & 32'h0000_FFFF;
    slow <= ^xs();
    for (int i = 0; i < cnt; i++) begin
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (ev !== 1'b1 && k < 3000);
      check(ev, 1'b1);
      x = {e_len[i], e_wr[i], i == cnt - 1, hd};
      check(elem.addr, e_addr[i]);
      check({elem.len, elem.write, elem.last, elem.head}, x);
      @(posedge clk);
      erdy <= 1'b1;
      @(posedge clk);
      erdy <= 1'b0;
    end
    @(posedge clk);
    done <= 1'b1;
    dlen <= dl;
    @(posedge clk);
    done <= 1'b0;
    k = 0;
    do begin
      apb(1'b0, `VQW_OFS_IDX, 32'h0);
      k++;
    end while (rd[31:16] !== uidx + 16'h1 && k < 100);
    s = 32'h181 + 2 * uidx[1:0];
    uidx++;
    check(rd, {uidx, aidx});
    check(vqw_mem_inst.mem[s], {16'h0, hd});
    check(vqw_mem_inst.mem[s+1], dl);
    check(vqw_mem_inst.mem[32'h180][31:16], uidx);
    repeat (40) @(posedge clk);
    check(irqs - i0, ei);
  endtask

  // Main sequence: reset, directed chains, random chains, error, reset.
  initial begin
    seed = 32'h0000_0016;
    {nrst, psel, pen, pwr, erdy, done, slow, er} = 8'h00;
    {paddr, pwdata, dlen, aidx, uidx, num_errors, checks} = 0;
    for (int i = 0; i < 1024; i++) vqw_mem_inst.mem[i] = 32'h0000_0000;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, `VQW_OFS_IDX, 32'h0);
    check(rd, 32'h0000_0000);
    apb(1'b0, 12'h01C, 32'h0);
    check({er, rd}, {1'b1, 32'h0000_0000});
    apb(1'b1, `VQW_OFS_QLOG, 32'h0000_0002);
    apb(1'b1, `VQW_OFS_AVAIL, 32'h0000_0400);
    apb(1'b1, `VQW_OFS_USED, 32'h0000_0600);
    apb(1'b0, `VQW_OFS_QLOG, 32'h0);
    check(rd, 32'h0000_0002);
    for (int j = 0; j < 4; j++) begin
      e_addr[j] = {xs(), xs()};
      e_len[j] = xs() & 32'h0000_FFFF;
      e_wr[j] = j == 3;
    end
    // Two linked descriptors end in an indirect one marked writable.
    desc(0, e_addr[0], e_len[0], 16'h0001, 16'h0001);
    desc(4, e_addr[1], e_len[1], 16'h0001, 16'h0002);
    desc(8, 64'h200, 32'h20, 16'h0006, 16'h0000);
    desc(32'h80, e_addr[2], e_len[2], 16'h0001, 16'h0001);
    desc(32'h84, e_addr[3], e_len[3], 16'h0002, 16'h0000);
    publish(16'h0, 16'h0, 16'h0);
    apb(1'b1, `VQW_OFS_CTRL, 32'h0000_0001);
    run(16'h0, 4, 1'b1);
    // Random direct chains, readable before writable, event index later.
    for (int k = 0; k < 12; k++) begin
      if (k == 6) apb(1'b1, `VQW_OFS_CTRL, 32'h0000_0003);
      h = 16'(xs() & 32'h3);
      n = 1 + int'(xs() & 32'h3);
      nw = int'(xs() % (n + 1));
      for (int j = 0; j < n; j++) begin
        e_addr[j] = {xs(), xs()};
        e_len[j] = xs() & 32'h0000_FFFF;
        e_wr[j] = j >= n - nw;
        w = 4 * ((h + j) & 3);
        desc(w, e_addr[j], e_len[j], {14'h0, e_wr[j], j < n - 1},
             16'((h + j + 1) & 3));
      end
      fl = (k >= 6) ? 16'h0 : 16'(xs() & 32'h1);
      ue = uidx + 16'(xs() & 32'h1);
      publish(h, fl, ue);
      run(h, n, want(k >= 6, fl, ue));
    end
    // Indirect with continuation set halts the walker
    desc(0, 64'h200, 32'h20, 16'h0005, 16'h0001);
    publish(16'h0, 16'h0, 16'h0);
    halt_code(`VQW_ERR_INDNEXT);
    // A table entry that points to another table
    desc(32'h80, 64'h200, 32'h20, 16'h0004, 16'h0000);
    desc(0, 64'h200, 32'h20, 16'h0004, 16'h0000);
    apb(1'b1, `VQW_OFS_CTRL, 32'h0000_0001);
    halt_code(`VQW_ERR_NEST);
    // The same pending slot now names a head beyond the table.
    put_h(32'h101, 1'b1, 16'h0005);
    apb(1'b1, `VQW_OFS_CTRL, 32'h0000_0001);
    halt_code(`VQW_ERR_RANGE);
    // A looped chain runs past the queue size
    put_h(32'h101, 1'b1, 16'h0000);
    for (int j = 0; j < 4; j++) begin
      desc(4 * j, 64'h0, 32'h10, 16'h0001, 16'((j + 1) & 3));
    end
    erdy <= 1'b1;
    apb(1'b1, `VQW_OFS_CTRL, 32'h0000_0001);
    halt_code(`VQW_ERR_LONG);
    erdy <= 1'b0;
    check(vqw_mem_inst.bad_writes, 0);
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, `VQW_OFS_IDX, 32'h0);
    check(rd, 32'h0000_0000);
    summarize();
  end

  // The whole run needs some 2000 cycles; ten times that means a hang.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
